// *** rtl/clock_stop_pkg.sv ***
// Shared constants and carrier types for the clock output stop and power control block
package clock_stop_pkg;

	// ****************************************************************
	// Output, enable line and control counts
	// ****************************************************************
	localparam int REF_COUNT  = 11;
	localparam int PROC_COUNT = 2;
	localparam int BUS_COUNT  = 4;
	localparam int OE_DED     = 4;
	localparam int OE_COUNT   = 6;
	localparam int CTL_COUNT  = 9;

	// ****************************************************************
	// Control vector positions
	// ****************************************************************
	localparam int CTL_OE_A     = 4;
	localparam int CTL_OE_B     = 5;
	localparam int CTL_PD       = 6;
	localparam int CTL_PROC_STP = 7;
	localparam int CTL_BUS_STP  = 8;

	// Reference outputs owned by the dedicated enable lines 0..3
	localparam int OE_DED_REF [OE_DED] = '{0, 1, 3, 6};

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [CTL_COUNT-1:0] CTL_RESET_N = 9'h1BF; // Power-good role starts as not good

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_FREQ_MHZ       = 25;
	localparam int POWER_UP_US        = 1800;
	localparam int FLOAT_HIGH_US      = 300;
	// Longest times: round down to whole cycles
	localparam int POWER_UP_CYCLES    = POWER_UP_US * CLK_FREQ_MHZ;
	localparam int FLOAT_HIGH_CYCLES  = FLOAT_HIGH_US * CLK_FREQ_MHZ;
	localparam int TIMER_WIDTH        = 17;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		PWR_WAIT_GOOD,
		PWR_RUN,
		PWR_ENTRY,
		PWR_OFF,
		PWR_EXIT
	} power_state_type;

	typedef struct packed {
		logic [REF_COUNT-1:0]  ref_shared_a;
		logic [REF_COUNT-1:0]  ref_shared_b;
		logic [REF_COUNT-1:0]  ref_pd_float;
		logic [PROC_COUNT-1:0] proc_pd_float;
		logic [PROC_COUNT-1:0] proc_stoppable;
		logic                  display_pd_float;
		logic                  free_bus_free_run;
		logic                  spread_sel_96;
	} clock_config_type;

	typedef struct packed {
		logic [REF_COUNT-1:0]  ref_true;
		logic [REF_COUNT-1:0]  ref_comp;
		logic [PROC_COUNT-1:0] proc_true;
		logic [PROC_COUNT-1:0] proc_comp;
		logic [BUS_COUNT-1:0]  bus;
		logic                  free_bus;
		logic                  display_true;
		logic                  display_comp;
		logic                  spread_true;
		logic                  spread_comp;
	} clock_outputs_type;

endpackage

// *** rtl/clock_stop_lane.sv ***
// Group of output gates that stop and restart only during the low phase
`timescale 1ns/1ps
`default_nettype none

module clock_stop_lane #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	// Raw running clocks, sampled
	input  wire logic [WIDTH-1:0] raw_i,
	// Stop control
	input  wire logic [WIDTH-1:0] stop_i,
	input  wire logic [WIDTH-1:0] rest_high_i,
	input  wire logic [WIDTH-1:0] float_i,
	// Gated pins and stop status
	output logic      [WIDTH-1:0] true_o,
	output logic      [WIDTH-1:0] comp_o,
	output logic      [WIDTH-1:0] stopped_o
);

	logic [WIDTH-1:0] stopped_reg;
	logic [WIDTH-1:0] true_reg;
	logic [WIDTH-1:0] comp_reg;

	// ****************************************************************
	// Stop state changes only while the raw clock is low
	// ****************************************************************
	// A change during the high phase would cut or stretch a pulse
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			stopped_reg <= '1;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (!raw_i[i]) begin
					stopped_reg[i] <= stop_i[i];
				end
			end
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			true_reg <= '0;
			comp_reg <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (!stopped_reg[i]) begin
					true_reg[i] <= raw_i[i];
					comp_reg[i] <= ~raw_i[i];
				end else if (float_i[i]) begin
					true_reg[i] <= 1'b0;
					comp_reg[i] <= 1'b0;
				end else begin
					true_reg[i] <= rest_high_i[i];
					comp_reg[i] <= 1'b0;
				end
			end
		end
	end

	assign true_o    = true_reg;
	assign comp_o    = comp_reg;
	assign stopped_o = stopped_reg;

endmodule // clock_stop_lane

`default_nettype wire

// *** rtl/clock_output_stop_power_control.sv ***
// Output enable, stop and power-down sequencing for a multi-output clock generator
//
// Contract
// - enable valid after two equal complement-edge samples
// - dedicated lines own outputs; shared lines use config
// - enabled outputs restart together in 2-6 periods
// - disabled stoppable outputs halt low/low after transition
// - pin is power-good first, then power-down
// - synchronise power-down; stop clocks before oscillators off
// - two processor-edge samples; freeze at next low
// - drive-mode 0 rests high/low, 1 low/low
// - stable clocks within 1.8 ms of release
// - floated pairs driven high within 300 us
// - after lock all outputs enabled together
// - spread output follows display or reference group
// - processor stop halts stoppable pairs in 2-6 periods
// - halted processor pair high/low driven, low/low floated
// - processor clocks resume cleanly within two cycles
// - bus stop halts bus clocks, free-run ones excepted
// - bus clocks resume together within two periods
`timescale 1ns/1ps
`default_nettype none

module clock_output_stop_power_control #(
	parameter int POWER_UP_CYCLES   = clock_stop_pkg::POWER_UP_CYCLES,
	parameter int FLOAT_HIGH_CYCLES = clock_stop_pkg::FLOAT_HIGH_CYCLES
) (
	// Clock and reset
	input  wire logic                               clk_sys_i,
	input  wire logic                               rst_i,
	// Asynchronous control pins, active low
	input  wire logic [clock_stop_pkg::OE_COUNT-1:0] output_enable_n_i,
	input  wire logic                               powergood_powerdown_pin_i,
	input  wire logic                               processor_clock_stop_n_i,
	input  wire logic                               bus_clock_stop_n_i,
	// Configuration
	input  wire clock_stop_pkg::clock_config_type   cfg_i,
	// Raw internal clocks, sampled
	input  wire logic [clock_stop_pkg::REF_COUNT-1:0]  express_ref_clock_raw_i,
	input  wire logic [clock_stop_pkg::PROC_COUNT-1:0] processor_clock_raw_i,
	input  wire logic [clock_stop_pkg::BUS_COUNT-1:0]  bus_clock_raw_i,
	input  wire logic                               free_run_bus_clock_raw_i,
	input  wire logic                               display_clock_raw_i,
	input  wire logic                               display_or_spread_clock_raw_i,
	input  wire logic                               synth_locked_i,
	// Gated clocks
	output clock_stop_pkg::clock_outputs_type        clocks_o,
	// Power control
	output logic                                    oscillator_enable_o,
	output logic                                    synth_enable_o,
	output logic                                    power_down_n_o,
	output logic                                    power_up_late_o
);

	localparam int RC = clock_stop_pkg::REF_COUNT;
	localparam int PC = clock_stop_pkg::PROC_COUNT;
	localparam int BC = clock_stop_pkg::BUS_COUNT;
	localparam int CC = clock_stop_pkg::CTL_COUNT;
	localparam int TW = clock_stop_pkg::TIMER_WIDTH;

	// ****************************************************************
	// Edge detect on the governing clocks
	// ****************************************************************
	logic ref_prev_reg;
	logic proc_prev_reg;
	logic bus_prev_reg;
	logic ref_comp_rise;
	logic proc_comp_rise;
	logic bus_rise;
	logic [CC-1:0] ctl_edge;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ref_prev_reg  <= 1'b0;
			proc_prev_reg <= 1'b0;
			bus_prev_reg  <= 1'b0;
		end else begin
			ref_prev_reg  <= express_ref_clock_raw_i[0];
			proc_prev_reg <= processor_clock_raw_i[0];
			bus_prev_reg  <= bus_clock_raw_i[0];
		end
	end

	// Complement rises as true falls; power-down uses system edges while the oscillator is off
	assign ref_comp_rise  = ref_prev_reg & ~express_ref_clock_raw_i[0];
	assign proc_comp_rise = proc_prev_reg & ~processor_clock_raw_i[0];
	assign bus_rise       = ~bus_prev_reg & bus_clock_raw_i[0];
	assign ctl_edge = {bus_rise, proc_comp_rise, proc_comp_rise | ~oscillator_enable_o,
		{clock_stop_pkg::OE_COUNT{ref_comp_rise}}};

	// ****************************************************************
	// Synchroniser and two-sample debounce
	// ****************************************************************
	logic [CC-1:0] ctl_raw;
	logic [CC-1:0] sync1_reg;
	logic [CC-1:0] sync2_reg;
	logic [CC-1:0] sample_reg;
	logic [CC-1:0] ctl_n_reg;

	assign ctl_raw = {bus_clock_stop_n_i, processor_clock_stop_n_i, powergood_powerdown_pin_i,
		output_enable_n_i};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1_reg <= clock_stop_pkg::CTL_RESET_N;
			sync2_reg <= clock_stop_pkg::CTL_RESET_N;
		end else begin
			sync1_reg <= ctl_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// A level counts only when two successive governing edges agree
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sample_reg <= clock_stop_pkg::CTL_RESET_N;
			ctl_n_reg  <= clock_stop_pkg::CTL_RESET_N;
		end else begin
			for (int i = 0; i < CC; i++) begin
				if (ctl_edge[i]) begin
					sample_reg[i] <= sync2_reg[i];
					if (sample_reg[i] == sync2_reg[i]) begin
						ctl_n_reg[i] <= sync2_reg[i];
					end
				end
			end
		end
	end

	// ****************************************************************
	// Power sequencer
	// ****************************************************************
	clock_stop_pkg::power_state_type state_reg;
	logic [TW-1:0] timer_reg;
	logic          float_hold_reg;
	logic          late_reg;
	logic          pd_stop;
	logic          all_stopped;
	logic          pin_level;

	assign pin_level = ctl_n_reg[clock_stop_pkg::CTL_PD];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= clock_stop_pkg::PWR_WAIT_GOOD;
		end else begin
			case (state_reg)
				clock_stop_pkg::PWR_WAIT_GOOD: begin
					// Power-good role until first seen high
					if (pin_level) begin
						state_reg <= clock_stop_pkg::PWR_EXIT;
					end
				end
				clock_stop_pkg::PWR_RUN: begin
					if (!pin_level) begin
						state_reg <= clock_stop_pkg::PWR_ENTRY;
					end
				end
				clock_stop_pkg::PWR_ENTRY: begin
					// Oscillators stay on until every output is parked
					if (all_stopped) begin
						state_reg <= clock_stop_pkg::PWR_OFF;
					end
				end
				clock_stop_pkg::PWR_OFF: begin
					if (pin_level) begin
						state_reg <= clock_stop_pkg::PWR_EXIT;
					end
				end
				clock_stop_pkg::PWR_EXIT: begin
					if (!pin_level) begin
						state_reg <= clock_stop_pkg::PWR_ENTRY;
					end else if (synth_locked_i) begin
						state_reg <= clock_stop_pkg::PWR_RUN;
					end
				end
				default: begin
					state_reg <= clock_stop_pkg::PWR_WAIT_GOOD;
				end
			endcase
		end
	end

	// Time since release, for the float hold and the late flag
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			timer_reg <= '0;
		end else if (state_reg != clock_stop_pkg::PWR_EXIT) begin
			timer_reg <= '0;
		end else if (timer_reg != '1) begin
			timer_reg <= timer_reg + TW'(1);
		end
	end

	// Floated pairs turn to driven-high once the release timer reaches the float-high limit, or on entering run
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			float_hold_reg <= 1'b1;
		end else if (state_reg == clock_stop_pkg::PWR_ENTRY) begin
			float_hold_reg <= 1'b1;
		end else if (state_reg == clock_stop_pkg::PWR_EXIT
			&& timer_reg >= TW'(FLOAT_HIGH_CYCLES - 1)) begin
			float_hold_reg <= 1'b0;
		end else if (state_reg == clock_stop_pkg::PWR_RUN) begin
			float_hold_reg <= 1'b0;
		end
	end

	// Lock not seen in time is reported, not masked
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			late_reg <= 1'b0;
		end else if (state_reg == clock_stop_pkg::PWR_EXIT
			&& timer_reg >= TW'(POWER_UP_CYCLES)) begin
			late_reg <= 1'b1;
		end else if (state_reg == clock_stop_pkg::PWR_RUN) begin
			late_reg <= 1'b0;
		end
	end

	assign pd_stop = state_reg != clock_stop_pkg::PWR_RUN;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			oscillator_enable_o <= 1'b0;
			synth_enable_o      <= 1'b0;
			power_down_n_o      <= 1'b0;
		end else begin
			oscillator_enable_o <= state_reg == clock_stop_pkg::PWR_EXIT
				|| state_reg == clock_stop_pkg::PWR_RUN || state_reg == clock_stop_pkg::PWR_ENTRY;
			synth_enable_o      <= state_reg == clock_stop_pkg::PWR_EXIT
				|| state_reg == clock_stop_pkg::PWR_RUN || state_reg == clock_stop_pkg::PWR_ENTRY;
			power_down_n_o      <= ~pd_stop;
		end
	end

	assign power_up_late_o = late_reg;

	// ****************************************************************
	// Stop requests per group
	// ****************************************************************
	logic [RC-1:0] ref_oe_stop;
	logic [RC-1:0] ref_stop;
	logic [RC-1:0] ref_float;
	logic [PC-1:0] proc_stop;
	logic [PC-1:0] proc_float;
	logic [BC-1:0] bus_stop;
	logic          free_stop;
	logic          bus_stop_req;
	logic [1:0]    disp_stop;
	logic [1:0]    disp_float;
	logic [RC-1:0] ref_stopped;
	logic [PC-1:0] proc_stopped;
	logic [BC-1:0] bus_stopped;
	logic          free_stopped;
	logic [1:0]    disp_stopped;

	always_comb begin
		ref_oe_stop = '0;
		for (int i = 0; i < clock_stop_pkg::OE_DED; i++) begin
			if (ctl_n_reg[i]) begin
				ref_oe_stop[clock_stop_pkg::OE_DED_REF[i]] = 1'b1;
			end
		end
		if (ctl_n_reg[clock_stop_pkg::CTL_OE_A]) begin
			ref_oe_stop = ref_oe_stop | cfg_i.ref_shared_a;
		end
		if (ctl_n_reg[clock_stop_pkg::CTL_OE_B]) begin
			ref_oe_stop = ref_oe_stop | cfg_i.ref_shared_b;
		end
	end

	// Shared release of a line frees its outputs on the same edge
	assign ref_stop  = ref_oe_stop | {RC{pd_stop}};
	assign ref_float = cfg_i.ref_pd_float & {RC{pd_stop & float_hold_reg}};

	assign proc_stop  = ({PC{~ctl_n_reg[clock_stop_pkg::CTL_PROC_STP]}} & cfg_i.proc_stoppable)
		| {PC{pd_stop}};
	assign proc_float = cfg_i.proc_pd_float & {PC{pd_stop ? float_hold_reg : 1'b1}};

	assign bus_stop_req = ~ctl_n_reg[clock_stop_pkg::CTL_BUS_STP];
	assign bus_stop     = {BC{bus_stop_req | pd_stop}};
	assign free_stop    = (bus_stop_req & ~cfg_i.free_bus_free_run) | pd_stop;

	assign disp_stop  = {2{pd_stop}};
	assign disp_float = {cfg_i.spread_sel_96 ? cfg_i.display_pd_float : cfg_i.ref_pd_float[0],
		cfg_i.display_pd_float} & {2{float_hold_reg}};

	assign all_stopped = &{ref_stopped, proc_stopped, bus_stopped, free_stopped, disp_stopped};

	// ****************************************************************
	// Output gates
	// ****************************************************************
	clock_stop_lane #(.WIDTH(RC)) ref_lane (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.raw_i      (express_ref_clock_raw_i),
		.stop_i     (ref_stop),
		.rest_high_i({RC{pd_stop}} & ~ref_oe_stop),
		.float_i    (ref_float),
		.true_o     (clocks_o.ref_true),
		.comp_o     (clocks_o.ref_comp),
		.stopped_o  (ref_stopped)
	);

	clock_stop_lane #(.WIDTH(PC)) proc_lane (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.raw_i      (processor_clock_raw_i),
		.stop_i     (proc_stop),
		.rest_high_i({PC{1'b1}}),
		.float_i    (proc_float),
		.true_o     (clocks_o.proc_true),
		.comp_o     (clocks_o.proc_comp),
		.stopped_o  (proc_stopped)
	);

	// Single-ended bus clocks always park low
	clock_stop_lane #(.WIDTH(BC + 1)) bus_lane (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.raw_i      ({free_run_bus_clock_raw_i, bus_clock_raw_i}),
		.stop_i     ({free_stop, bus_stop}),
		.rest_high_i('0),
		.float_i    ('0),
		.true_o     ({clocks_o.free_bus, clocks_o.bus}),
		.comp_o     (),
		.stopped_o  ({free_stopped, bus_stopped})
	);

	clock_stop_lane #(.WIDTH(2)) disp_lane (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.raw_i      ({display_or_spread_clock_raw_i, display_clock_raw_i}),
		.stop_i     (disp_stop),
		.rest_high_i(2'h3),
		.float_i    (disp_float),
		.true_o     ({clocks_o.spread_true, clocks_o.display_true}),
		.comp_o     ({clocks_o.spread_comp, clocks_o.display_comp}),
		.stopped_o  (disp_stopped)
	);

endmodule // clock_output_stop_power_control

`default_nettype wire

// *** dv/control_host_model.sv ***
// Host-side model that drives the asynchronous clock control pins
`timescale 1ns/1ps
`default_nettype none

module control_host_model #(
	parameter int MIN_HOLD = 24
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Requested levels
	input  wire logic [5:0] want_oe_n_i,
	input  wire logic       want_pin_i,
	input  wire logic       want_proc_stop_n_i,
	input  wire logic       want_bus_stop_n_i,
	// Pins
	output logic      [5:0] output_enable_n_o,
	output logic            powergood_powerdown_pin_o,
	output logic            processor_clock_stop_n_o,
	output logic            bus_clock_stop_n_o
);
	logic [8:0] want;
	logic [8:0] pins_reg;
	int         held;

	assign want = {want_bus_stop_n_i, want_proc_stop_n_i, want_pin_i, want_oe_n_i};
	assign {bus_clock_stop_n_o, processor_clock_stop_n_o, powergood_powerdown_pin_o,
		output_enable_n_o} = pins_reg;

	// Hold spans three governing edges; 24 cycles is still far inside the 10 us limit
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pins_reg <= want;
			held     <= 0;
		end else if (want != pins_reg && held >= MIN_HOLD) begin
			pins_reg <= want;
			held     <= 0;
		end else begin
			held <= held + 1;
		end
	end
endmodule // control_host_model
`default_nettype wire

// *** dv/clock_stop_sva.sv ***
// Assertion checker for the clock output stop and power control block
`timescale 1ns/1ps
`default_nettype none

module clock_stop_sva (
	// Clock and reset
	input wire logic                                 clk_sys_i,
	input wire logic                                 rst_i,
	// Control pins and configuration
	input wire logic [clock_stop_pkg::OE_COUNT-1:0]  output_enable_n_i,
	input wire logic                                 powergood_powerdown_pin_i,
	input wire logic                                 processor_clock_stop_n_i,
	input wire logic                                 bus_clock_stop_n_i,
	input wire clock_stop_pkg::clock_config_type     cfg_i,
	// Raw clocks
	input wire logic [clock_stop_pkg::REF_COUNT-1:0] express_ref_clock_raw_i,
	input wire logic [clock_stop_pkg::BUS_COUNT-1:0] bus_clock_raw_i,
	input wire logic                                 free_run_bus_clock_raw_i,
	input wire logic                                 synth_locked_i,
	// Outputs
	input wire clock_stop_pkg::clock_outputs_type    clocks_o,
	input wire logic                                 oscillator_enable_o,
	input wire logic                                 power_down_n_o
);
	logic [7:0] pin_hi, pin_lo, oe0_hi, oe0_lo, proc_lo, bus_lo, bus_hi, run_cnt;
	logic       seen_run;

	function automatic logic [7:0] sat(input logic c, input logic [7:0] n);
		return c ? ((n == 8'hFF) ? n : n + 8'h01) : 8'h00;
	endfunction

	// ********
	// Level ages: stop rules bind only once a level has settled
	// ********
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			{pin_hi, pin_lo, oe0_hi, oe0_lo, proc_lo, bus_lo, bus_hi, run_cnt} <= '0;
			seen_run <= 1'b0;
		end else begin
			pin_hi   <= sat(powergood_powerdown_pin_i, pin_hi);
			pin_lo   <= sat(!powergood_powerdown_pin_i, pin_lo);
			oe0_hi   <= sat(output_enable_n_i[0], oe0_hi);
			oe0_lo   <= sat(!output_enable_n_i[0], oe0_lo);
			proc_lo  <= sat(!processor_clock_stop_n_i, proc_lo);
			bus_lo   <= sat(!bus_clock_stop_n_i, bus_lo);
			bus_hi   <= sat(bus_clock_stop_n_i, bus_hi);
			run_cnt  <= sat(power_down_n_o, run_cnt);
			seen_run <= seen_run | power_down_n_o;
		end
	end

	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_reset_quiet: assert property ($fell(rst_i) |-> clocks_o == '0 && !power_down_n_o)
		else $error("outputs not quiet after reset");
	a_good_first: assert property (pin_lo >= 8'h18 && !oscillator_enable_o |=> !oscillator_enable_o)
		else $error("oscillator started while pin low");
	a_osc_after_park: assert property ($fell(oscillator_enable_o) |-> clocks_o.bus == '0
		&& !clocks_o.free_bus && $stable(clocks_o)) else $error("oscillator off before park");
	a_pd_park_level: assert property (seen_run && pin_lo >= 8'h40 |->
		clocks_o.ref_true == ~cfg_i.ref_pd_float && clocks_o.ref_comp == '0
		&& clocks_o.proc_true == ~cfg_i.proc_pd_float && clocks_o.proc_comp == '0
		&& clocks_o.bus == '0 && !clocks_o.free_bus && !clocks_o.display_comp
		&& clocks_o.display_true == !cfg_i.display_pd_float) else $error("bad park level");
	a_spread_follows: assert property (seen_run && pin_lo >= 8'h40 |-> !clocks_o.spread_comp
		&& clocks_o.spread_true == !(cfg_i.spread_sel_96 ? cfg_i.display_pd_float
		: cfg_i.ref_pd_float[0])) else $error("spread park wrong");
	a_power_up_time: assert property (pin_hi >= 8'h3C && oscillator_enable_o && synth_locked_i
		|-> ##[0:2] power_down_n_o) else $error("not running after lock");
	a_oe_stop: assert property (oe0_hi >= 8'h50 && run_cnt >= 8'h50 |->
		!clocks_o.ref_true[0] && !clocks_o.ref_comp[0]) else $error("ref0 not stopped");
	a_oe_run: assert property (oe0_lo >= 8'h50 && run_cnt >= 8'h50 |->
		clocks_o.ref_true[0] == $past(express_ref_clock_raw_i[0])) else $error("ref0 not running");
	a_proc_park: assert property (proc_lo >= 8'h50 && run_cnt >= 8'h50 |->
		(clocks_o.proc_true & cfg_i.proc_stoppable) == (~cfg_i.proc_pd_float & cfg_i.proc_stoppable)
		&& (clocks_o.proc_comp & cfg_i.proc_stoppable) == '0) else $error("bad proc park");
	a_bus_stop: assert property (bus_lo >= 8'h30 && run_cnt >= 8'h50 |-> clocks_o.bus == '0
		&& (!cfg_i.free_bus_free_run || clocks_o.free_bus == $past(free_run_bus_clock_raw_i)))
		else $error("bus stop wrong");
	a_bus_resume: assert property (bus_hi >= 8'h30 && run_cnt >= 8'h50 |->
		clocks_o.bus == $past(bus_clock_raw_i)) else $error("bus not resumed");

	c_power_off: cover property ($fell(oscillator_enable_o));
	c_proc_stop: cover property (proc_lo == 8'h50 && run_cnt >= 8'h50);
	c_bus_stop: cover property (bus_lo == 8'h30 && run_cnt >= 8'h50);
endmodule // clock_stop_sva
`default_nettype wire

// *** dv/clock_output_stop_power_control_tb.sv ***
// Testbench for the clock output stop and power control block
`timescale 1ns/1ps
`default_nettype none

module clock_output_stop_power_control_tb;
	localparam int SETTLE = 80;
	localparam int LIMIT  = 6000;

	logic                              clk_sys_i = 1'b0;
	logic                              rst_i = 1'b1;
	logic [5:0]                        want_oe_n = 6'h00;
	logic                              want_pin = 1'b0;
	logic                              want_ps_n = 1'b1;
	logic                              want_bs_n = 1'b1;
	logic [5:0]                        oe_n;
	logic                              pin, ps_n, bs_n, raw;
	logic [2:0]                        raw_cnt = 3'h0;
	logic [7:0]                        lock_cnt = 8'h00;
	logic                              locked = 1'b0;
	logic                              osc_en, synth_en, pd_n, late;
	clock_stop_pkg::clock_config_type  cfg;
	clock_stop_pkg::clock_outputs_type clocks, tog, prev, e;
	int                                failures = 0;
	int                                n_tests = 0;
	int                                cycles = 0;

	always #20 clk_sys_i = ~clk_sys_i;
	assign raw = raw_cnt[2] & osc_en;

	// Raw clocks at 1/8 rate, low while the oscillator is off; lock 24 cycles after enable
	always @(posedge clk_sys_i) begin
		raw_cnt  <= raw_cnt + 3'h1;
		lock_cnt <= synth_en ? ((lock_cnt == 8'hFF) ? lock_cnt : lock_cnt + 8'h01) : 8'h00;
		locked   <= lock_cnt >= 8'h18;
		cycles   <= cycles + 1;
		if (cycles == LIMIT) begin
			failures++;
			give_verdict();
		end
	end

	clock_output_stop_power_control #(.POWER_UP_CYCLES(40), .FLOAT_HIGH_CYCLES(10)) i_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .output_enable_n_i(oe_n),
		.powergood_powerdown_pin_i(pin), .processor_clock_stop_n_i(ps_n),
		.bus_clock_stop_n_i(bs_n), .cfg_i(cfg), .express_ref_clock_raw_i({11{raw}}),
		.processor_clock_raw_i({2{raw}}), .bus_clock_raw_i({4{raw}}),
		.free_run_bus_clock_raw_i(raw), .display_clock_raw_i(raw),
		.display_or_spread_clock_raw_i(raw), .synth_locked_i(locked), .clocks_o(clocks),
		.oscillator_enable_o(osc_en), .synth_enable_o(synth_en), .power_down_n_o(pd_n),
		.power_up_late_o(late));

	control_host_model i_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .want_oe_n_i(want_oe_n),
		.want_pin_i(want_pin), .want_proc_stop_n_i(want_ps_n), .want_bus_stop_n_i(want_bs_n),
		.output_enable_n_o(oe_n), .powergood_powerdown_pin_o(pin),
		.processor_clock_stop_n_o(ps_n), .bus_clock_stop_n_o(bs_n));

	// ********
	// Access tasks
	// ********
	task automatic check(input string name, input logic [34:0] exp, input logic [34:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic drive(input logic [5:0] oe, input logic p, input logic ps, input logic bs);
		@(posedge clk_sys_i);
		want_oe_n <= oe;
		want_pin  <= p;
		want_ps_n <= ps;
		want_bs_n <= bs;
		repeat (SETTLE) @(posedge clk_sys_i);
	endtask

	// Collects which output bits moved over two raw periods
	task automatic observe();
		tog = '0;
		prev = clocks;
		repeat (16) begin
			@(posedge clk_sys_i);
			#1;
			tog = tog | (clocks ^ prev);
			prev = clocks;
		end
	endtask

	task automatic power_up(input bit float_chk);
		int n;
		@(posedge clk_sys_i);
		want_pin <= 1'b1;
		n = 0;
		while (osc_en !== 1'b1 && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		repeat (16) @(posedge clk_sys_i);
		#1;
		if (float_chk)
			check("floated refs high", {24'h0, 11'h7FF}, {24'h0, clocks.ref_true});
		n = 0;
		while (pd_n !== 1'b1 && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		check("run flags", 35'h1, {33'h0, late, pd_n});
		observe();
		check("all running", '1, tog);
	endtask

	task automatic stop_case(input string name, input logic [5:0] oe, input logic ps,
			input logic bs, input clock_stop_pkg::clock_outputs_type halted);
		drive(oe, 1'b1, ps, bs);
		observe();
		check({name, " toggles"}, ~halted, tog);
		check({name, " rest"}, '0, prev & halted);
		drive(6'h00, 1'b1, 1'b1, 1'b1);
		observe();
		check({name, " resumed"}, '1, tog);
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		int k;
		cfg = '0;
		cfg.ref_shared_a = 11'h100;
		cfg.ref_shared_b = 11'h200;
		cfg.ref_pd_float = 11'h004;
		cfg.proc_pd_float = 2'h1;
		cfg.proc_stoppable = 2'h1;
		cfg.display_pd_float = 1'b1;
		cfg.free_bus_free_run = 1'b1;
		cfg.spread_sel_96 = 1'b1;
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		check("reset outputs", '0, clocks);
		repeat (40) @(posedge clk_sys_i);
		check("waiting for good", '0, {32'h0, osc_en, synth_en, pd_n});
		power_up(1'b0);
		for (int i = 0; i < 6; i++) begin
			k = (i < 4) ? clock_stop_pkg::OE_DED_REF[i] : 4 + i;
			e = '0;
			e.ref_true[k] = 1'b1;
			e.ref_comp[k] = 1'b1;
			stop_case("enable line", 6'h01 << i, 1'b1, 1'b1, e);
		end
		e = '0;
		e.proc_true[0] = 1'b1;
		e.proc_comp[0] = 1'b1;
		stop_case("processor stop", 6'h00, 1'b0, 1'b1, e);
		e = '0;
		e.bus = '1;
		stop_case("bus stop", 6'h00, 1'b1, 1'b0, e);
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk_sys_i);
			cfg.spread_sel_96 <= s[0];
			drive(6'h00, 1'b0, 1'b1, 1'b1);
			#1;
			check("off flags", '0, {32'h0, osc_en, synth_en, pd_n});
			observe();
			check("frozen", '0, tog);
			e = '0;
			e.ref_true = ~cfg.ref_pd_float;
			e.proc_true = ~cfg.proc_pd_float;
			e.display_true = ~cfg.display_pd_float;
			e.spread_true = s[0] ? ~cfg.display_pd_float : ~cfg.ref_pd_float[0];
			check("parked", e, prev);
			power_up(1'b1);
		end
		give_verdict();
	end
endmodule // clock_output_stop_power_control_tb

bind clock_output_stop_power_control clock_stop_sva i_sva (.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .output_enable_n_i(output_enable_n_i),
	.powergood_powerdown_pin_i(powergood_powerdown_pin_i),
	.processor_clock_stop_n_i(processor_clock_stop_n_i),
	.bus_clock_stop_n_i(bus_clock_stop_n_i), .cfg_i(cfg_i),
	.express_ref_clock_raw_i(express_ref_clock_raw_i), .bus_clock_raw_i(bus_clock_raw_i),
	.free_run_bus_clock_raw_i(free_run_bus_clock_raw_i), .synth_locked_i(synth_locked_i),
	.clocks_o(clocks_o), .oscillator_enable_o(oscillator_enable_o),
	.power_down_n_o(power_down_n_o));
`default_nettype wire
